// ==== bbsle_pkg.sv ====
`default_nettype none
package bbsle_pkg;

  // Status flag bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Low register index of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam int REG_COUNT = 32;

  // Register map on the software bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam int CTRL_RUN_POS = 0;

  // Reset values
  localparam logic RUN_RST = 1'h1;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP, OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_BR_SIGNED_GE, OP_BR_SIGNED_LT,
    OP_IO_SET, OP_IO_CLR, OP_SHL, OP_SHR, OP_ROT_L, OP_ROT_R, OP_SHR_ARITH,
    OP_SWAP, OP_FLAG_SET, OP_FLAG_CLR, OP_BIT_TO_T, OP_T_TO_BIT, OP_REG_COPY,
    OP_PAIR_COPY, OP_LOAD_CONST, OP_LOAD_PTR, OP_LOAD_PTR_INC, OP_LOAD_PTR_DEC,
    OP_LOAD_OFFSET
  } bbsle_op_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } bbsle_ptr_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_FINISH = 2'h1
  } bbsle_state_t;

endpackage
`default_nettype wire

// ==== bbsle_alu_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface bbsle_alu_if;
  import bbsle_pkg::*;
  bbsle_op_t op;
  logic [7:0] operand;
  logic [2:0] bitSel;
  logic [7:0] flagsIn;
  logic [7:0] result;
  logic [7:0] flagsOut;
  modport core (output op, operand, bitSel, flagsIn, input result, flagsOut);
  modport unit (input op, operand, bitSel, flagsIn, output result, flagsOut);
endinterface
`default_nettype wire

// ==== bbsle_alu.sv ====
`timescale 1ns/100ps
`default_nettype none
module bbsle_alu
  import bbsle_pkg::*;
(
  bbsle_alu_if.unit alu
);

  logic [7:0] opnd;
  logic cIn;
  logic [7:0] bitMask;

  // Flags after a shift; S is left as it was
  function automatic logic [7:0] shiftFlags(input logic [7:0] f, input logic [7:0] r,
                                            input logic c);
    logic [7:0] o;
    o = f;
    o[FLAG_Z] = (r == 8'h00);
    o[FLAG_C] = c;
    o[FLAG_N] = r[7];
    o[FLAG_V] = r[7] ^ c;
    return o;
  endfunction

  // Operand views
  assign opnd = alu.operand;
  assign cIn = alu.flagsIn[FLAG_C];
  assign bitMask = 8'h01 << alu.bitSel;

  // Result and flags; anything not listed passes through unchanged
  always_comb begin
    alu.result = opnd;
    alu.flagsOut = alu.flagsIn;
    case (alu.op)
      OP_SHL: begin
        alu.result = {opnd[6:0], 1'b0};
        alu.flagsOut = shiftFlags(alu.flagsIn, {opnd[6:0], 1'b0}, opnd[7]);
      end
      OP_SHR: begin
        alu.result = {1'b0, opnd[7:1]};
        alu.flagsOut = shiftFlags(alu.flagsIn, {1'b0, opnd[7:1]}, opnd[0]);
      end
      OP_ROT_L: begin
        alu.result = {opnd[6:0], cIn};
        alu.flagsOut = shiftFlags(alu.flagsIn, {opnd[6:0], cIn}, opnd[7]);
      end
      OP_ROT_R: begin
        alu.result = {cIn, opnd[7:1]};
        alu.flagsOut = shiftFlags(alu.flagsIn, {cIn, opnd[7:1]}, opnd[0]);
      end
      OP_SHR_ARITH: begin
        alu.result = {opnd[7], opnd[7:1]};
        alu.flagsOut = shiftFlags(alu.flagsIn, {opnd[7], opnd[7:1]}, opnd[0]);
      end
      OP_SWAP: begin
        alu.result = {opnd[3:0], opnd[7:4]};
      end
      OP_FLAG_SET: begin
        alu.flagsOut = alu.flagsIn | bitMask;
      end
      OP_FLAG_CLR: begin
        alu.flagsOut = alu.flagsIn & ~bitMask;
      end
      OP_BIT_TO_T: begin
        alu.flagsOut[FLAG_T] = |(opnd & bitMask);
      end
      OP_T_TO_BIT: begin
        alu.result = alu.flagsIn[FLAG_T] ? (opnd | bitMask) : (opnd & ~bitMask);
      end
      default: begin
        alu.result = opnd;
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== bbsle_exec.sv ====
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module bbsle_exec
  import bbsle_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int ADDR_W = 8
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instrValid,
  output logic instrReady,
  input wire bbsle_op_t instrOp,
  input wire logic [4:0] instrDst,
  input wire logic [4:0] instrSrc,
  input wire logic [2:0] instrBit,
  input wire bbsle_ptr_t instrPtr,
  input wire logic [7:0] instrImm,
  output logic memRd,
  output logic [15:0] memAddr,
  input wire logic [7:0] memRdata,
  output logic ioRd,
  output logic ioWr,
  output logic [7:0] ioAddr,
  input wire logic [7:0] ioRdata,
  output logic [7:0] ioWdata,
  output logic [7:0] statusFlags,
  output logic [PC_W-1:0] progCounter,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  logic [7:0] regFile [REG_COUNT];
  bbsle_state_t state_ff, nxtState;
  logic instrReady_ff, run_ff, memRd_ff, ioRd_ff, ioWr_ff, pendSet_ff, pendLoad_ff;
  logic [15:0] memAddr_ff;
  logic [7:0] ioAddr_ff, ioWdata_ff, flags_ff;
  logic [2:0] pendBit_ff;
  logic [4:0] pendDst_ff;
  logic [PC_W-1:0] pc_ff, nxtPc, branchTarget;
  logic accept, flagBit, nvXor, brTaken, isIo, isLoad, isAluWr, regWr, twoCycle;
  logic [4:0] ptrLo, ptrHi, dstHi, srcHi;
  logic [15:0] ptrVal, ptrNew, loadAddr;
  logic [7:0] rdVal, rrVal, regWrData, ioMask;
  bbsle_alu_if aluBus();

  // Register index of the chosen pointer pair
  function automatic logic [4:0] ptrBase(input bbsle_ptr_t p);
    case (p)
      PTR_X: return PTR_X_LO;
      PTR_Y: return PTR_Y_LO;
      default: return PTR_Z_LO;
    endcase
  endfunction

  // Register map hit, shared by read and write paths
  function automatic logic regHit(input logic [ADDR_W-1:0] a);
    return (a == ADDR_W'(ADDR_CTRL)) || (a == ADDR_W'(ADDR_FLAGS)) || (a == ADDR_W'(ADDR_PC));
  endfunction

  // Operand fetch from the register file
  assign accept = instrValid & instrReady_ff;
  assign rdVal = regFile[instrDst];
  assign rrVal = regFile[instrSrc];
  assign ptrLo = ptrBase(instrPtr);
  assign ptrHi = ptrLo | 5'h01;
  assign dstHi = instrDst | 5'h01;
  assign srcHi = instrSrc | 5'h01;
  assign ptrVal = {regFile[ptrHi], regFile[ptrLo]};

  assign flagBit = flags_ff[instrBit];
  assign nvXor = flags_ff[FLAG_N] ^ flags_ff[FLAG_V];
  assign branchTarget = pc_ff + PC_W'(signed'(instrImm)) + PC_W'(1);
  assign brTaken = accept & (((instrOp == OP_BR_FLAG_SET) & flagBit) |
                             ((instrOp == OP_BR_FLAG_CLR) & ~flagBit) |
                             ((instrOp == OP_BR_SIGNED_GE) & ~nvXor) |
                             ((instrOp == OP_BR_SIGNED_LT) & nvXor));

  // Instruction classes
  assign isIo = (instrOp == OP_IO_SET) | (instrOp == OP_IO_CLR);
  assign isLoad = (instrOp == OP_LOAD_PTR) | (instrOp == OP_LOAD_PTR_INC) |
                  (instrOp == OP_LOAD_PTR_DEC) | (instrOp == OP_LOAD_OFFSET);
  assign isAluWr = (instrOp == OP_SHL) | (instrOp == OP_SHR) | (instrOp == OP_ROT_L) |
                   (instrOp == OP_ROT_R) | (instrOp == OP_SHR_ARITH) |
                   (instrOp == OP_SWAP) | (instrOp == OP_T_TO_BIT);
  assign twoCycle = brTaken | (accept & (isIo | isLoad));

  assign ptrNew = (instrOp == OP_LOAD_PTR_DEC) ? ptrVal - 16'h0001 : ptrVal + 16'h0001;
  assign loadAddr = (instrOp == OP_LOAD_PTR_DEC) ? ptrNew :
                    (instrOp == OP_LOAD_OFFSET) ? ptrVal + {8'h00, instrImm} : ptrVal;

  assign regWr = accept & (isAluWr | (instrOp == OP_REG_COPY) |
                           (instrOp == OP_PAIR_COPY) | (instrOp == OP_LOAD_CONST));
  assign regWrData = isAluWr ? aluBus.result :
                     (instrOp == OP_LOAD_CONST) ? instrImm : rrVal;

  // Shift and flag unit
  assign aluBus.op = accept ? instrOp : OP_NOP;
  assign aluBus.operand = (instrOp == OP_BIT_TO_T) ? rrVal : rdVal;
  assign aluBus.bitSel = instrBit;
  assign aluBus.flagsIn = flags_ff;

  bbsle_alu u_bbsle_alu (
    .alu(aluBus.unit)
  );

  // Two-cycle instructions hold off the next one for one cycle
  always_comb begin
    case (state_ff)
      ST_EXEC: nxtState = twoCycle ? ST_FINISH : ST_EXEC;
      ST_FINISH: nxtState = ST_EXEC;
      default: nxtState = ST_EXEC;
    endcase
  end

  assign nxtPc = brTaken ? branchTarget : accept ? pc_ff + PC_W'(1) : pc_ff;
  assign ioMask = 8'h01 << pendBit_ff;

  // Sequencer, program counter and flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_EXEC;
      instrReady_ff <= 1'b0;
      pc_ff <= '0;
      flags_ff <= FLAGS_RST;
    end else begin
      state_ff <= nxtState;
      instrReady_ff <= run_ff & (nxtState == ST_EXEC);
      pc_ff <= nxtPc;
      flags_ff <= aluBus.flagsOut;
    end
  end

  // Memory and I/O request side; the I/O write trails its read by one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memRd_ff <= 1'b0;
      memAddr_ff <= 16'h0000;
      ioRd_ff <= 1'b0;
      ioWr_ff <= 1'b0;
      ioAddr_ff <= 8'h00;
      ioWdata_ff <= 8'h00;
      pendSet_ff <= 1'b0;
      pendLoad_ff <= 1'b0;
      pendBit_ff <= 3'h0;
      pendDst_ff <= 5'h00;
    end else begin
      memRd_ff <= accept & isLoad;
      ioRd_ff <= accept & isIo;
      ioWr_ff <= ioRd_ff;
      pendLoad_ff <= accept & isLoad;
      if (accept) begin
        pendSet_ff <= (instrOp == OP_IO_SET);
        pendBit_ff <= instrBit;
        pendDst_ff <= instrDst;
      end
      if (accept & isLoad) begin
        memAddr_ff <= loadAddr;
      end
      if (accept & isIo) begin
        ioAddr_ff <= instrImm;
      end
      if (ioRd_ff) begin
        ioWdata_ff <= pendSet_ff ? (ioRdata | ioMask) : (ioRdata & ~ioMask);
      end
    end
  end

  // Register file; data storage, so no reset
  always_ff @(posedge clk) begin
    if (regWr) begin
      regFile[instrDst] <= regWrData;
    end
    if (accept & (instrOp == OP_PAIR_COPY)) begin
      regFile[dstHi] <= regFile[srcHi];
    end
    if (accept & ((instrOp == OP_LOAD_PTR_INC) | (instrOp == OP_LOAD_PTR_DEC))) begin
      regFile[ptrLo] <= ptrNew[7:0];
      regFile[ptrHi] <= ptrNew[15:8];
    end
    if (pendLoad_ff) begin
      regFile[pendDst_ff] <= memRdata;
    end
  end

  // Software bus: write address and data taken in either order
  logic awready_ff, wready_ff, awHeld_ff, wHeld_ff, wLane0_ff, bvalid_ff;
  logic arready_ff, rvalid_ff, awTake, wTake, doWrite, nxtAwHeld, nxtWHeld;
  logic nxtBvalid, arTake, nxtRvalid;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff, rdata_ff, rdMux;
  logic [1:0] bresp_ff, rresp_ff;

  assign awTake = awvalid & awready_ff;
  assign wTake = wvalid & wready_ff;
  assign doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
  assign nxtAwHeld = (awHeld_ff | awTake) & ~doWrite;
  assign nxtWHeld = (wHeld_ff | wTake) & ~doWrite;
  assign nxtBvalid = doWrite | (bvalid_ff & ~bready);
  assign arTake = arvalid & arready_ff;
  assign nxtRvalid = arTake | (rvalid_ff & ~rready);
  assign rdMux = (araddr == ADDR_W'(ADDR_CTRL)) ? {31'h00000000, run_ff} :
                 (araddr == ADDR_W'(ADDR_FLAGS)) ? {24'h000000, flags_ff} :
                 (araddr == ADDR_W'(ADDR_PC)) ? 32'(pc_ff) : 32'h00000000;

  // Write side; flags and PC read only, unmapped answers with an error
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= 32'h00000000;
      wLane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      run_ff <= RUN_RST;
    end else begin
      awHeld_ff <= nxtAwHeld;
      wHeld_ff <= nxtWHeld;
      bvalid_ff <= nxtBvalid;
      awready_ff <= ~nxtAwHeld & ~nxtBvalid;
      wready_ff <= ~nxtWHeld & ~nxtBvalid;
      if (awTake) begin
        awAddr_ff <= awaddr;
      end
      if (wTake) begin
        wData_ff <= wdata;
        wLane0_ff <= wstrb[0];
      end
      if (doWrite) begin
        bresp_ff <= regHit(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
        if ((awAddr_ff == ADDR_W'(ADDR_CTRL)) & wLane0_ff) begin
          run_ff <= wData_ff[CTRL_RUN_POS];
        end
      end
    end
  end

  // Read side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxtRvalid;
      arready_ff <= ~nxtRvalid;
      if (arTake) begin
        rdata_ff <= rdMux;
        rresp_ff <= regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Outputs straight from flip-flops
  assign instrReady = instrReady_ff;
  assign memRd = memRd_ff;
  assign memAddr = memAddr_ff;
  assign ioRd = ioRd_ff;
  assign ioWr = ioWr_ff;
  assign ioAddr = ioAddr_ff;
  assign ioWdata = ioWdata_ff;
  assign statusFlags = flags_ff;
  assign progCounter = pc_ff;
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  brTaken_pc_a: assert property (
    accept && instrOp == OP_BR_FLAG_SET && flagBit |=>
      pc_ff == $past(branchTarget) && !instrReady_ff ##1 state_ff == ST_EXEC)
    else $error("taken flag branch missed target or timing");
  brNotTaken_a: assert property (
    accept && instrOp == OP_BR_FLAG_CLR && flagBit |=>
      pc_ff == $past(pc_ff) + PC_W'(1) && state_ff == ST_EXEC)
    else $error("untaken branch did not fall through");
  signedGe_a: assert property (
    accept && instrOp == OP_BR_SIGNED_GE && !nvXor |=>
      pc_ff == $past(branchTarget) && flags_ff == $past(flags_ff))
    else $error("signed ge branch wrong");
  signedLt_a: assert property (
    accept && instrOp == OP_BR_SIGNED_LT |=>
      pc_ff == ($past(nvXor) ? $past(branchTarget) : $past(pc_ff) + PC_W'(1)))
    else $error("signed lt branch wrong");
  irqBranch_a: assert property (
    accept && instrOp == OP_BR_FLAG_CLR && instrBit == FLAG_I && !flags_ff[FLAG_I] |=>
      pc_ff == $past(branchTarget))
    else $error("interrupt-disabled branch not taken");
  ioBitWrite_a: assert property (
    accept && isIo |=> ioRd_ff && !instrReady_ff ##1
      ioWr_ff && (ioWdata_ff & ~ioMask) == ($past(ioRdata) & ~ioMask) &&
      ioWdata_ff[pendBit_ff] == pendSet_ff)
    else $error("I/O bit write corrupted");
  shiftLeft_a: assert property (
    accept && instrOp == OP_SHL |=>
      regFile[$past(instrDst)] == {$past(rdVal[6:0]), 1'b0} &&
      flags_ff[FLAG_C] == $past(rdVal[7]))
    else $error("left shift result or carry wrong");
  rotRight_a: assert property (
    accept && instrOp == OP_ROT_R |=>
      regFile[$past(instrDst)] == {$past(flags_ff[FLAG_C]), $past(rdVal[7:1])} &&
      flags_ff[FLAG_C] == $past(rdVal[0]))
    else $error("rotate right wrong");
  flagForce_a: assert property (
    accept && instrOp == OP_FLAG_SET |=>
      flags_ff == ($past(flags_ff) | (8'h01 << $past(instrBit))))
    else $error("flag set touched other flags");
  loadInc_a: assert property (
    accept && instrOp == OP_LOAD_PTR_INC |=>
      memRd_ff && memAddr_ff == $past(ptrVal) ##1 !memRd_ff)
    else $error("post-increment load address wrong");
  loadDec_a: assert property (
    accept && instrOp == OP_LOAD_PTR_DEC |=>
      memAddr_ff == $past(ptrVal) - 16'h0001 && flags_ff == $past(flags_ff))
    else $error("pre-decrement load address wrong");
  copyOne_a: assert property (
    accept && instrOp == OP_REG_COPY |=>
      regFile[$past(instrDst)] == $past(rrVal) && state_ff == ST_EXEC &&
      flags_ff == $past(flags_ff))
    else $error("register copy wrong");

  cov_taken_c: cover property (brTaken);
  cov_load_c: cover property (accept && instrOp == OP_LOAD_OFFSET ##3 accept);
  cov_io_c: cover property (ioWr_ff);
  cov_bus_c: cover property (bvalid_ff && bready && bresp_ff == RESP_SLVERR);

endmodule
`default_nettype wire

// ==== tb_branch_bit_shift_load_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_branch_bit_shift_load_exec;
  import bbsle_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic instrValid = 1'b0;
  bbsle_op_t instrOp = OP_NOP;
  bbsle_ptr_t instrPtr = PTR_X;
  logic [4:0] instrDst = 5'h00;
  logic [4:0] instrSrc = 5'h00;
  logic [2:0] instrBit = 3'h0;
  logic [7:0] instrImm = 8'h00;
  logic [7:0] memRdata = 8'h00;
  logic [7:0] ioRdata = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic instrReady, memRd, ioRd, ioWr, awready, wready, bvalid, arready, rvalid;
  logic [15:0] memAddr, progCounter;
  logic [7:0] ioAddr, ioWdata, statusFlags;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int numErrors = 0;
  int numChecks = 0;
  logic [15:0] pcExp = 16'h0000;
  logic [7:0] flExp = 8'h00;

  bbsle_exec #(.PC_W(16), .ADDR_W(8)) u_bbsle_exec (
    .clk(clk), .rst_b(rst_b), .instrValid(instrValid), .instrReady(instrReady),
    .instrOp(instrOp), .instrDst(instrDst), .instrSrc(instrSrc), .instrBit(instrBit),
    .instrPtr(instrPtr), .instrImm(instrImm), .memRd(memRd), .memAddr(memAddr),
    .memRdata(memRdata), .ioRd(ioRd), .ioWr(ioWr), .ioAddr(ioAddr), .ioRdata(ioRdata),
    .ioWdata(ioWdata), .statusFlags(statusFlags), .progCounter(progCounter),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  // Core clock, 100 ns period
  always #50 clk = ~clk;

  task summarize;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task checkVal(input string name, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task checkCore(input logic rdy);
    checkVal("pc", pcExp, progCounter);
    checkVal("ready", rdy, instrReady);
    checkVal("flags", flExp, statusFlags);
  endtask

  // Offer one instruction and hold it until taken; results land 1 ns after
  task exec(input bbsle_op_t op, input logic [4:0] d, input logic [4:0] s,
            input logic [2:0] b, input logic [7:0] k, input bbsle_ptr_t p = PTR_X);
    int n;
    @(posedge clk);
    instrValid <= 1'b1;
    instrOp <= op;
    instrDst <= d;
    instrSrc <= s;
    instrBit <= b;
    instrImm <= k;
    instrPtr <= p;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instrReady !== 1'b1 && n < 20);
    instrValid <= 1'b0;
    #1;
    checkVal("taken", 1'b1, n < 20);
  endtask

  task step(input bbsle_op_t op, input logic [4:0] d, input logic [4:0] s,
            input logic [2:0] b, input logic [7:0] k);
    exec(op, d, s, b, k);
    pcExp += 16'h0001;
    checkCore(1'b1);
  endtask

  task setFlag(input logic [2:0] b, input logic v);
    flExp[b] = v;
    step(v ? OP_FLAG_SET : OP_FLAG_CLR, 5'h00, 5'h00, b, 8'h00);
  endtask

  task branch(input bbsle_op_t op, input logic [2:0] b, input logic [7:0] k, input logic tk);
    exec(op, 5'h00, 5'h00, b, k);
    pcExp = tk ? pcExp + {{8{k[7]}}, k} + 16'h0001 : pcExp + 16'h0001;
    checkCore(!tk);
  endtask

  // Registers have no read port: copy into X low byte and watch the load address
  task readReg(input logic [4:0] i, input logic [7:0] e);
    step(OP_REG_COPY, 5'h1A, i, 3'h0, 8'h00);
    step(OP_LOAD_CONST, 5'h1B, 5'h00, 3'h0, 8'h00);
    exec(OP_LOAD_PTR, 5'h01, 5'h00, 3'h0, 8'h00, PTR_X);
    pcExp += 16'h0001;
    checkVal("reg", {8'h00, e}, memAddr);
  endtask

  task load(input bbsle_op_t op, input bbsle_ptr_t p, input logic [4:0] d,
            input logic [7:0] k, input logic [15:0] a);
    exec(op, d, 5'h00, 3'h0, k, p);
    pcExp += 16'h0001;
    checkCore(1'b0);
    checkVal("memRd", 1'b1, memRd);
    checkVal("memAddr", a, memAddr);
    @(posedge clk);
    #1;
    checkVal("memRd", 1'b0, memRd);
    checkVal("ready", 1'b1, instrReady);
  endtask

  task io(input bbsle_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w);
    exec(op, 5'h00, 5'h00, b, a);
    pcExp += 16'h0001;
    checkCore(1'b0);
    checkVal("ioRd", 1'b1, ioRd);
    checkVal("ioAddr", a, ioAddr);
    @(posedge clk);
    #1;
    checkVal("ioWr", 1'b1, ioWr);
    checkVal("ioWdata", w, ioWdata);
    checkVal("ioRd", 1'b0, ioRd);
  endtask

  task shiftCase(input bbsle_op_t op, input logic [7:0] v, input logic c,
                 input logic [7:0] r, input logic co);
    setFlag(FLAG_C, c);
    step(OP_LOAD_CONST, 5'h10, 5'h00, 3'h0, v);
    flExp[FLAG_C] = co;
    flExp[FLAG_Z] = (r == 8'h00);
    flExp[FLAG_N] = r[7];
    flExp[FLAG_V] = r[7] ^ co;
    step(op, 5'h10, 5'h00, 3'h0, 8'h00);
    readReg(5'h10, r);
  endtask

  // Write and read masters: valid held until its own ready, then dropped
  task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    checkVal("bvalid", 1'h1, bvalid);
    checkVal("bresp", r, bresp);
  endtask

  task axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    checkVal("rvalid", 1'h1, rvalid);
    checkVal("rdata", d, rdata);
    checkVal("rresp", r, rresp);
  endtask

  task testFlags;
    for (int i = 0; i < 8; i++) setFlag(i[2:0], 1'b1);
    for (int i = 0; i < 8; i++) setFlag(i[2:0], 1'b0);
    $display("test flags done");
  endtask

  task testBranch;
    for (int b = 0; b < 8; b++) begin
      setFlag(b[2:0], 1'b0);
      branch(OP_BR_FLAG_SET, b[2:0], 8'h05, 1'b0);
      branch(OP_BR_FLAG_CLR, b[2:0], 8'hFD, 1'b1);
      setFlag(b[2:0], 1'b1);
      branch(OP_BR_FLAG_SET, b[2:0], 8'h7F, 1'b1);
      branch(OP_BR_FLAG_CLR, b[2:0], 8'h80, 1'b0);
    end
    for (int c = 0; c < 4; c++) begin
      setFlag(FLAG_N, c[1]);
      setFlag(FLAG_V, c[0]);
      branch(OP_BR_SIGNED_GE, 3'h0, 8'hF0, c[1] == c[0]);
      branch(OP_BR_SIGNED_LT, 3'h0, 8'h10, c[1] != c[0]);
    end
    $display("test branch done");
  endtask

  // S and H set first so that an unwanted update shows
  task testShift;
    setFlag(FLAG_S, 1'b1);
    setFlag(FLAG_H, 1'b1);
    shiftCase(OP_SHL, 8'h96, 1'b1, 8'h2C, 1'b1);
    shiftCase(OP_SHL, 8'h40, 1'b0, 8'h80, 1'b0);
    shiftCase(OP_SHR, 8'h01, 1'b1, 8'h00, 1'b1);
    shiftCase(OP_SHR, 8'hFE, 1'b1, 8'h7F, 1'b0);
    shiftCase(OP_ROT_L, 8'h80, 1'b1, 8'h01, 1'b1);
    shiftCase(OP_ROT_L, 8'h41, 1'b0, 8'h82, 1'b0);
    shiftCase(OP_ROT_R, 8'h01, 1'b0, 8'h00, 1'b1);
    shiftCase(OP_ROT_R, 8'h02, 1'b1, 8'h81, 1'b0);
    shiftCase(OP_SHR_ARITH, 8'h81, 1'b0, 8'hC0, 1'b1);
    shiftCase(OP_SHR_ARITH, 8'h7E, 1'b1, 8'h3F, 1'b0);
    $display("test shift done");
  endtask

  task testMove;
    step(OP_LOAD_CONST, 5'h10, 5'h00, 3'h0, 8'hA5);
    step(OP_SWAP, 5'h10, 5'h00, 3'h0, 8'h00);
    readReg(5'h10, 8'h5A);
    flExp[FLAG_T] = 1'b1;
    step(OP_BIT_TO_T, 5'h00, 5'h10, 3'h1, 8'h00);
    step(OP_LOAD_CONST, 5'h11, 5'h00, 3'h0, 8'h00);
    step(OP_T_TO_BIT, 5'h11, 5'h00, 3'h7, 8'h00);
    flExp[FLAG_T] = 1'b0;
    step(OP_BIT_TO_T, 5'h00, 5'h10, 3'h0, 8'h00);
    step(OP_LOAD_CONST, 5'h12, 5'h00, 3'h0, 8'hFF);
    step(OP_T_TO_BIT, 5'h12, 5'h00, 3'h3, 8'h00);
    readReg(5'h12, 8'hF7);
    step(OP_PAIR_COPY, 5'h14, 5'h10, 3'h0, 8'h00);
    step(OP_REG_COPY, 5'h16, 5'h11, 3'h0, 8'h00);
    readReg(5'h14, 8'h5A);
    readReg(5'h15, 8'h80);
    readReg(5'h16, 8'h80);
    $display("test move done");
  endtask

  // Z pointer value chosen so increment and decrement carry across the byte boundary
  task testLoad;
    @(posedge clk);
    memRdata <= 8'h3C;
    step(OP_LOAD_CONST, 5'h1C, 5'h00, 3'h0, 8'h23);
    step(OP_LOAD_CONST, 5'h1D, 5'h00, 3'h0, 8'h01);
    load(OP_LOAD_PTR, PTR_Y, 5'h02, 8'h00, 16'h0123);
    load(OP_LOAD_PTR_INC, PTR_Y, 5'h03, 8'h00, 16'h0123);
    load(OP_LOAD_PTR, PTR_Y, 5'h03, 8'h00, 16'h0124);
    load(OP_LOAD_PTR_DEC, PTR_Y, 5'h03, 8'h00, 16'h0123);
    load(OP_LOAD_OFFSET, PTR_Y, 5'h03, 8'hF0, 16'h0213);
    load(OP_LOAD_PTR, PTR_Y, 5'h03, 8'h00, 16'h0123);
    step(OP_LOAD_CONST, 5'h1E, 5'h00, 3'h0, 8'hFF);
    step(OP_LOAD_CONST, 5'h1F, 5'h00, 3'h0, 8'h00);
    load(OP_LOAD_PTR_INC, PTR_Z, 5'h04, 8'h00, 16'h00FF);
    load(OP_LOAD_PTR_DEC, PTR_Z, 5'h04, 8'h00, 16'h00FF);
    load(OP_LOAD_OFFSET, PTR_Z, 5'h04, 8'h3F, 16'h013E);
    readReg(5'h02, 8'h3C);
    load(OP_LOAD_PTR_DEC, PTR_X, 5'h04, 8'h00, 16'h003B);
    load(OP_LOAD_PTR_INC, PTR_X, 5'h04, 8'h00, 16'h003B);
    load(OP_LOAD_PTR, PTR_X, 5'h04, 8'h00, 16'h003C);
    $display("test load done");
  endtask

  task testIo;
    @(posedge clk);
    ioRdata <= 8'h5A;
    io(OP_IO_SET, 8'h3F, 3'h0, 8'h5B);
    io(OP_IO_SET, 8'h00, 3'h7, 8'hDA);
    io(OP_IO_CLR, 8'h20, 3'h1, 8'h58);
    io(OP_IO_CLR, 8'hFF, 3'h2, 8'h5A);
    $display("test io done");
  endtask

  task testAxi;
    axiRead(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    axiWrite(ADDR_FLAGS, 32'h000000FF, RESP_OKAY);
    axiRead(ADDR_FLAGS, {24'h000000, flExp}, RESP_OKAY);
    axiWrite(8'h10, 32'h00000001, RESP_SLVERR);
    axiRead(8'h10, 32'h00000000, RESP_SLVERR);
    axiWrite(ADDR_CTRL, 32'h00000000, RESP_OKAY);
    @(posedge clk);
    #1;
    checkVal("halted", 1'b0, instrReady);
    axiRead(ADDR_PC, {16'h0000, pcExp}, RESP_OKAY);
    axiWrite(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    @(posedge clk);
    #1;
    checkVal("running", 1'b1, instrReady);
    $display("test axi done");
  endtask

  // Main sequence: reset held 4 cycles, then the scenarios
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    checkCore(1'b1);
    $display("test reset done");
    testFlags;
    testBranch;
    testShift;
    testMove;
    testLoad;
    testIo;
    testAxi;
    summarize;
  end

  // Watchdog, well beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    numErrors++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    summarize;
  end
endmodule
`default_nettype wire
